// file: rtl/lcd_cmd_decoder.sv
// Device end: serial receiver and command decoder of the LCD segment driver.
//
// Behaviour
// [RULE1] Decode received command-flagged bytes into operations.
// [RULE2] Mode-set 1100: on, bias, drive mode.
// [RULE3] Drive mode picks one to four backplanes.
// [RULE4] Bias bit: 0 third, 1 half.
// [RULE5] Static mode ignores the bias bit.
// [RULE6] Display off blanks all outputs to supply.
// [RULE7] Bit7 clear loads seven-bit data pointer.
// [RULE8] Device-select 111000 loads subaddress counter.
// [RULE9] Bank-select bit1 steers incoming data rows.
// [RULE10] Bank-select bit0 chooses displayed rows.
// [RULE11] Three/four backplane modes ignore bank-select.
// [RULE12] Blink-select 11110 carries blink mode, rate.
// [RULE13] Host may blink by toggling display-on.
// [RULE14] Blink bit2 alternates banks; bits1-0 rate.
// [RULE15] Pointer advances eight, four, three, two.
// [RULE16] Store only on subaddress match; overflow increments.
// [RULE17] Unknown commands leave settings unchanged.
// [RULE18] Settings change only after acknowledged byte.
module lcd_cmd_decoder
  import lcd_cmd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  lcd_link_if.dev link,
  input wire logic hw_subaddr_bit_lo_i,
  input wire logic hw_subaddr_bit_hi_i,
  output logic display_on_o,
  output logic blank_o,
  output logic bias_half_o,
  output logic [1:0] drive_mode_o,
  output logic [2:0] backplanes_o,
  output logic [6:0] data_ptr_o,
  output logic [1:0] subaddr_cnt_o,
  output logic in_bank_o,
  output logic out_bank_o,
  output logic alt_bank_blink_bit_o,
  output logic [1:0] blink_rate_field_o,
  output logic ram_we_o,
  output logic [6:0] ram_addr_o,
  output logic [7:0] ram_data_o,
  output logic ram_row_bank_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] sub_lo_q;
  logic [1:0] sub_hi_q;

  // Stage 0 feeds only stage 1; edges compare stages 1 and 2.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 3'h0_007;
      sda_q <= 3'h0_007;
      sub_lo_q <= 2'h0_000;
      sub_hi_q <= 2'h0_000;
    end else begin
      scl_q <= {scl_q[1:0], link.scl};
      sda_q <= {sda_q[1:0], link.sda};
      sub_lo_q <= {sub_lo_q[0], hw_subaddr_bit_lo_i};
      sub_hi_q <= {sub_hi_q[0], hw_subaddr_bit_hi_i};
    end
  end

  // Link events seen by the core clock.
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  wire [1:0] hw_subaddr = {sub_hi_q[1], sub_lo_q[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Byte receiver with acknowledge.
  dev_state_e state_r;
  dev_state_e state_nxt;
  logic [8:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic ack_drv_r;

  // The byte is acted on only as the acknowledge clock ends.
  wire exec = (state_r == DEV_ACK) & scl_fall; // [RULE18]
  wire byte_done = (state_r == DEV_BITS) & scl_fall & (bit_cnt_r == 4'(FRAME_BITS));

  // Next-state logic: start and stop override everything.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DEV_IDLE: begin
        if (start_det) begin
          state_nxt = DEV_BITS;
        end
      end
      DEV_BITS: begin
        if (byte_done) begin
          state_nxt = DEV_ACK;
        end
      end
      DEV_ACK: begin
        if (exec) begin
          state_nxt = DEV_BITS;
        end
      end
      default: begin
        state_nxt = DEV_IDLE;
      end
    endcase
    if (stop_det) begin
      state_nxt = DEV_IDLE;
    end else if (start_det) begin
      state_nxt = DEV_BITS;
    end
  end

  // Shift in flag and byte on rising link clock, most significant first.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= DEV_IDLE;
      shift_r <= 9'h0_000;
      bit_cnt_r <= 4'h0_000;
      ack_drv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_det || exec) begin
        bit_cnt_r <= 4'h0_000;
      end else if (state_r == DEV_BITS && scl_rise && bit_cnt_r != 4'(FRAME_BITS)) begin
        shift_r <= {shift_r[7:0], sda_q[1]};
        bit_cnt_r <= bit_cnt_r + 4'h0_001;
      end
      ack_drv_r <= byte_done | (ack_drv_r & ~exec & ~stop_det & ~start_det);
    end
  end

  // The acknowledge line is pulled low only during the acknowledge clock.
  assign link.serial_ack_output = 1'b0;
  assign link.serial_ack_output_oe_n = ~ack_drv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  logic display_on_r;
  logic bias_r;
  logic [1:0] mode_r;
  logic [6:0] ptr_r;
  logic [1:0] subaddr_r;
  logic in_bank_r;
  logic out_bank_r;
  logic blink_alt_r;
  logic [1:0] blink_rate_r;

  wire is_cmd = shift_r[CMD_FLAG_BIT];
  wire [7:0] rx_byte = shift_r[7:0];
  wire low_mux = (mode_r == MODE_STATIC) | (mode_r == MODE_MUX2);
  wire dec_mode = exec & is_cmd & (rx_byte[7:4] == MODE_SET_PAT); // [RULE1] [RULE2]
  wire dec_ptr = exec & is_cmd & ~rx_byte[7]; // [RULE7]
  wire dec_dev = exec & is_cmd & (rx_byte[7:2] == DEV_SEL_PAT); // [RULE8]
  wire dec_bank = exec & is_cmd & (rx_byte[7:2] == BANK_SEL_PAT) & low_mux; // [RULE11]
  wire dec_blink = exec & is_cmd & (rx_byte[7:3] == BLINK_SEL_PAT); // [RULE12]
  wire dec_data = exec & ~is_cmd;

  // Pointer step per drive mode, and wrap past the last address.
  wire [7:0] step = (mode_r == MODE_STATIC) ? STEP_STATIC :
                    (mode_r == MODE_MUX2) ? STEP_MUX2 :
                    (mode_r == MODE_MUX3) ? STEP_MUX3 : STEP_MUX4; // [RULE15]
  wire [7:0] ptr_sum = {1'b0, ptr_r} + step;
  wire ptr_ovf = ptr_sum > PTR_LAST;
  wire [7:0] ptr_wrap = ptr_sum - PTR_COUNT;
  wire [6:0] ptr_adv = ptr_ovf ? ptr_wrap[6:0] : ptr_sum[6:0];
  wire addr_match = subaddr_r == hw_subaddr; // [RULE16]

  // Settings registers; bytes matching no pattern fall through untouched.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      display_on_r <= DISPLAY_ON_RST;
      bias_r <= BIAS_RST;
      mode_r <= MODE_RST;
      in_bank_r <= 1'b0;
      out_bank_r <= 1'b0;
      blink_alt_r <= 1'b0;
      blink_rate_r <= BLINK_RATE_RST;
    end else begin
      if (dec_mode) begin
        display_on_r <= rx_byte[MODE_ON_BIT]; // [RULE6] [RULE13]
        bias_r <= rx_byte[MODE_BIAS_BIT]; // [RULE4]
        mode_r <= rx_byte[1:0]; // [RULE3]
      end
      if (dec_bank) begin
        in_bank_r <= rx_byte[BANK_IN_BIT]; // [RULE9]
        out_bank_r <= rx_byte[BANK_OUT_BIT]; // [RULE10]
      end
      if (dec_blink) begin
        blink_alt_r <= rx_byte[BLINK_ALT_BIT]; // [RULE14]
        blink_rate_r <= rx_byte[1:0]; // [RULE14]
      end
    end
  end

  // Pointer and subaddress counter; data bytes advance even when not stored.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_r <= PTR_RST;
      subaddr_r <= SUBADDR_RST;
    end else if (dec_ptr) begin
      ptr_r <= rx_byte[6:0]; // [RULE7]
    end else if (dec_dev) begin
      subaddr_r <= rx_byte[1:0]; // [RULE8]
    end else if (dec_data) begin
      ptr_r <= ptr_adv; // [RULE15]
      subaddr_r <= subaddr_r + {1'b0, ptr_ovf}; // [RULE16]
    end
  end

  // Display RAM write port, one pulse per stored byte.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ram_we_o <= 1'b0;
      ram_addr_o <= PTR_RST;
      ram_data_o <= 8'h0_000;
      ram_row_bank_o <= 1'b0;
    end else begin
      ram_we_o <= dec_data & addr_match; // [RULE16]
      if (dec_data) begin
        ram_addr_o <= ptr_r;
        ram_data_o <= rx_byte;
        ram_row_bank_o <= in_bank_r & low_mux; // [RULE9] [RULE11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings seen by the display timing and drive logic.
  assign display_on_o = display_on_r;
  assign blank_o = ~display_on_r; // [RULE6]
  assign bias_half_o = bias_r & (mode_r != MODE_STATIC); // [RULE5]
  assign drive_mode_o = mode_r;
  assign backplanes_o = (mode_r == MODE_MUX4) ? 3'h0_004 : {1'b0, mode_r}; // [RULE3]
  assign data_ptr_o = ptr_r;
  assign subaddr_cnt_o = subaddr_r;
  assign in_bank_o = in_bank_r & low_mux; // [RULE11]
  assign out_bank_o = out_bank_r & low_mux; // [RULE10] [RULE11]
  assign alt_bank_blink_bit_o = blink_alt_r;
  assign blink_rate_field_o = blink_rate_r;

endmodule : lcd_cmd_decoder

// file: rtl/lcd_cmd_host.sv
// Host end: sends one flagged byte per frame over the serial link.
module lcd_cmd_host
  import lcd_cmd_pkg::*;
#(
  parameter int TICK_CYC = LINK_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  lcd_link_if.host link
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider: one tick per link phase.
  logic [7:0] div_r;
  wire tick = div_r == 8'h0_000;

  // Free-running tick counter.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 8'h0_000;
    end else begin
      div_r <= tick ? 8'(TICK_CYC - 1) : div_r - 8'h0_001;
    end
  end

  // Acknowledge line synchroniser.
  logic [1:0] ack_q;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 2'h0_003;
    end else begin
      ack_q <= {ack_q[0], link.ack_line};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: start, flag and byte, acknowledge, stop.
  host_state_e state_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic scl_r;
  logic sda_drv_r;
  logic sda_val_r;
  logic nack_r;

  wire busy = state_r != H_IDLE;
  wire tx_wr = wr_i & (addr_i == HOST_TX_ADDR) & ~busy;
  wire ph_last = ph_r == 2'h0_002;

  // Phase 2 drops the clock, phase 0 sets data, phase 1 raises the clock.
  // Data therefore never moves in the tick in which the clock rises.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= H_IDLE;
      ph_r <= 2'h0_000;
      bit_r <= 4'h0_000;
      tx_r <= 9'h0_000;
      scl_r <= 1'b1;
      sda_drv_r <= 1'b0;
      sda_val_r <= 1'b1;
      nack_r <= 1'b0;
    end else if (tx_wr) begin
      tx_r <= wdata_i[8:0];
      state_r <= H_START;
      sda_drv_r <= 1'b1;
      sda_val_r <= 1'b0;
    end else if (tick && busy) begin
      ph_r <= ph_last ? 2'h0_000 : ph_r + 2'h0_001;
      case (state_r)
        H_START: begin
          scl_r <= 1'b0;
          state_r <= H_BITS;
          ph_r <= 2'h0_000;
          bit_r <= 4'(FRAME_BITS - 1);
        end
        H_BITS: begin
          if (ph_r == 2'h0_000) begin
            sda_val_r <= tx_r[bit_r];
          end
          scl_r <= ph_r == 2'h0_001;
          if (ph_last) begin
            bit_r <= bit_r - 4'h0_001;
            state_r <= (bit_r == 4'h0_000) ? H_ACK : H_BITS;
          end
        end
        H_ACK: begin
          if (ph_r == 2'h0_000) begin
            sda_drv_r <= 1'b0;
          end
          scl_r <= ph_r == 2'h0_001;
          if (ph_last) begin
            nack_r <= ack_q[1];
            state_r <= H_STOP;
          end
        end
        H_STOP: begin
          if (ph_r == 2'h0_000) begin
            sda_drv_r <= 1'b1;
            sda_val_r <= 1'b0;
          end
          if (ph_r == 2'h0_001) begin
            scl_r <= 1'b1;
          end
          if (ph_last) begin
            sda_drv_r <= 1'b0;
            sda_val_r <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.scl = scl_r;
  assign link.host_sda_out = sda_val_r;
  assign link.host_sda_oe_n = ~sda_drv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data only in the cycle after the strobe.
  wire [15:0] stat_word = {14'h0_000, nack_r, busy};
  wire [15:0] rd_mux = (addr_i == HOST_STAT_ADDR) ? stat_word :
                       (addr_i == HOST_TX_ADDR) ? {7'h0_000, tx_r} : 16'h0_000;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0_000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 16'h0_000;
    end
  end

endmodule : lcd_cmd_host

// file: rtl/lcd_cmd_pkg.sv
// Shared constants, encodings and state types of the LCD command link.
package lcd_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte patterns and fields.
  localparam logic [3:0] MODE_SET_PAT = 4'h0_00C;
  localparam logic [5:0] DEV_SEL_PAT = 6'h0_038;
  localparam logic [5:0] BANK_SEL_PAT = 6'h0_03E;
  localparam logic [4:0] BLINK_SEL_PAT = 5'h0_01E;
  localparam int MODE_ON_BIT = 3;
  localparam int MODE_BIAS_BIT = 2;
  localparam int BANK_IN_BIT = 1;
  localparam int BANK_OUT_BIT = 0;
  localparam int BLINK_ALT_BIT = 2;
  localparam int CMD_FLAG_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Drive modes and the pointer step that each one uses.
  localparam logic [1:0] MODE_STATIC = 2'h0_001;
  localparam logic [1:0] MODE_MUX2 = 2'h0_002;
  localparam logic [1:0] MODE_MUX3 = 2'h0_003;
  localparam logic [1:0] MODE_MUX4 = 2'h0_000;
  localparam logic [7:0] STEP_STATIC = 8'h0_008;
  localparam logic [7:0] STEP_MUX2 = 8'h0_004;
  localparam logic [7:0] STEP_MUX3 = 8'h0_003;
  localparam logic [7:0] STEP_MUX4 = 8'h0_002;
  localparam logic [7:0] PTR_LAST = 8'h0_04F;
  localparam logic [7:0] PTR_COUNT = 8'h0_050;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the decoded settings.
  localparam logic DISPLAY_ON_RST = 1'b0;
  localparam logic BIAS_RST = 1'b0;
  localparam logic [1:0] MODE_RST = MODE_MUX4;
  localparam logic [6:0] PTR_RST = 7'h0_000;
  localparam logic [1:0] SUBADDR_RST = 2'h0_000;
  localparam logic [1:0] BLINK_RATE_RST = 2'h0_000;

  ////////////////////////////////////////////////////////////////////////////
  // Host register map and link timing.
  localparam logic [1:0] HOST_TX_ADDR = 2'h0_000;
  localparam logic [1:0] HOST_STAT_ADDR = 2'h0_001;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int FRAME_BITS = 9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_TICK_NS = 40;
  localparam int LINK_TICK_CYC = (LINK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {DEV_IDLE, DEV_BITS, DEV_ACK} dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_ACK, H_STOP} host_state_e;

endpackage : lcd_cmd_pkg

// file: rtl/lcd_link_if.sv
// Serial link between the host controller and the LCD command decoder.
interface lcd_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic serial_ack_output;
  logic serial_ack_output_oe_n;
  logic sda;
  logic ack_line;

  // Both lines are pulled high when nobody drives them low.
  assign sda = host_sda_oe_n ? 1'b1 : host_sda_out;
  assign ack_line = serial_ack_output_oe_n ? 1'b1 : serial_ack_output;

  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe_n,
    input ack_line
  );

  modport dev (
    input scl,
    input sda,
    output serial_ack_output,
    output serial_ack_output_oe_n
  );
endinterface : lcd_link_if

// file: tb/lcd_link_sva.sv
// Checker of the serial link between the host end and the decoder end.
module lcd_link_sva #(
  parameter int TICK_CYC = 4
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic serial_ack_output,
  input wire logic serial_ack_output_oe_n,
  input wire logic sda,
  input wire logic ack_line
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [7:0] low_cnt_r;
  logic [3:0] bit_cnt_r;

  // Counts clock cycles of the low phase of the link clock.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt_r <= 8'h00;
    end else begin
      low_cnt_r <= scl ? 8'h00 : low_cnt_r + 8'h01;
    end
  end

  // Counts link clock rises since the start of a frame, wrapping to zero at the ack clock rise.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 4'h0;
    end else if ($fell(sda) && scl) begin
      bit_cnt_r <= 4'h0;
    end else if ($rose(scl)) begin
      bit_cnt_r <= (bit_cnt_r == 4'h9) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of a bit and of the acknowledge.
  sequence scl_high_phase;
    scl [*4];
  endsequence
  sequence sda_held;
    ##1 $stable(sda) [*2];
  endsequence
  sequence ack_held;
    !serial_ack_output_oe_n [*8];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Link clock shape and data stability.
  chk_scl_low_len: assert property ($rose(scl) |-> low_cnt_r == 8'(2 * TICK_CYC))
    else $error("link clock low phase has the wrong length");
  chk_scl_high_len: assert property ($rose(scl) |-> scl_high_phase)
    else $error("link clock high phase too short");
  chk_sda_stable_high: assert property ($rose(scl) |-> sda_held)
    else $error("data line moved while link clock high");
  chk_sda_setup: assert property ($rose(scl) |-> $stable(sda))
    else $error("data line moved as the link clock rose");

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge timing and level.
  chk_ack_pulls_low: assert property (!serial_ack_output_oe_n |-> !ack_line)
    else $error("ack line not low while device drives it");
  chk_ack_start_low: assert property ($fell(serial_ack_output_oe_n) |-> !scl)
    else $error("ack started while link clock high");
  chk_ack_after_ninth: assert property ($fell(serial_ack_output_oe_n) |->
    bit_cnt_r == 4'h9)
    else $error("ack not after the ninth bit");
  chk_ack_hold_len: assert property ($fell(serial_ack_output_oe_n) |-> ack_held)
    else $error("ack released too early");
  chk_ack_release_bnd: assert property ($fell(serial_ack_output_oe_n) |->
    ##[1:40] serial_ack_output_oe_n)
    else $error("ack held too long");
  chk_ack_over_high: assert property ($rose(scl) && !serial_ack_output_oe_n |->
    !serial_ack_output_oe_n [*3])
    else $error("ack dropped during ack clock high phase");
  // The host must have let go of the data line for the acknowledge clock.
  chk_ack_host_free: assert property ($rose(scl) && !serial_ack_output_oe_n |->
    host_sda_oe_n)
    else $error("host still drives data during the ack clock");
endmodule : lcd_link_sva

// file: tb/tb_top.sv
// Testbench joining the host end and the decoder end over the serial link.
module tb_top import lcd_cmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sub_lo = 1'b0;
  logic sub_hi = 1'b0;
  logic [15:0] rdata;
  logic display_on, blank, bias_half, in_bank, out_bank, alt_blink, ram_we, row_bank;
  logic [1:0] drive_mode, subaddr_cnt, blink_rate;
  logic [2:0] backplanes;
  logic [6:0] data_ptr, ram_addr;
  logic [7:0] ram_data;
  logic [7:0] steps [4] = '{STEP_STATIC, STEP_MUX2, STEP_MUX3, STEP_MUX4};
  int err_count = 0;
  int cmp_count = 0;
  int we_cnt = 0;

  // The host clock toggles every half period.
  always #5 ref_clk_i = ~ref_clk_i;

  // Counts store pulses into the display memory.
  always @(posedge ref_clk_i) begin
    if (ram_we === 1'b1) we_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both ends, the link and its checker.
  lcd_link_if link ();
  lcd_cmd_host #(.TICK_CYC(4)) lcd_cmd_host_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
  lcd_cmd_decoder lcd_cmd_decoder_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link),
    .hw_subaddr_bit_lo_i(sub_lo), .hw_subaddr_bit_hi_i(sub_hi), .display_on_o(display_on),
    .blank_o(blank), .bias_half_o(bias_half), .drive_mode_o(drive_mode),
    .backplanes_o(backplanes), .data_ptr_o(data_ptr), .subaddr_cnt_o(subaddr_cnt),
    .in_bank_o(in_bank), .out_bank_o(out_bank), .alt_bank_blink_bit_o(alt_blink),
    .blink_rate_field_o(blink_rate), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
    .ram_data_o(ram_data), .ram_row_bank_o(row_bank));
  lcd_link_sva #(.TICK_CYC(4)) lcd_link_sva_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .scl(link.scl), .host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
    .serial_ack_output(link.serial_ack_output),
    .serial_ack_output_oe_n(link.serial_ack_output_oe_n), .sda(link.sda),
    .ack_line(link.ack_line));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks for comparison and register access.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // Polls the status until the frame is done, then lets the decoder settle.
  task automatic wait_idle;
    logic [15:0] s;
    int n;
    s = 16'h0001;
    n = 0;
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
      reg_rd(HOST_STAT_ADDR, s);
      n++;
    end
    if (s[STAT_BUSY_BIT] !== 1'b0) begin
      err_count++;
      $display("[ERR] busy expected 0 seen 1");
      summarize();
    end
    chk("nack", 16'(s[STAT_NACK_BIT]), 16'h0000);
    repeat (8) @(posedge ref_clk_i);
  endtask : wait_idle

  task automatic send(input logic flag, input logic [7:0] b);
    reg_wr(HOST_TX_ADDR, {7'h00, flag, b});
    wait_idle();
  endtask : send

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    logic [1:0] m;
    logic [15:0] d;
    int w0;
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1;
    chk("rst_blank", 16'({blank, display_on, drive_mode, backplanes}), 16'h0044);
    chk("rst_ptr", 16'({data_ptr, subaddr_cnt, in_bank, out_bank}), 16'h0000);
    chk("rst_blink", 16'({alt_blink, blink_rate, ram_we}), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      send(1'b1, {MODE_SET_PAT, i[0], 1'b1, m});
      chk("drive_mode", 16'(drive_mode), 16'(m));
      chk("backplanes", 16'(backplanes), 16'(i + 1));
      chk("bias_half", 16'(bias_half), 16'(m != MODE_STATIC));
      chk("display", 16'({display_on, blank}), 16'({i[0], ~i[0]}));
      send(1'b1, 8'h10);
      chk("ptr_load", 16'(data_ptr), 16'h0010);
      send(1'b0, 8'h80 + 8'(i));
      chk("ram_wr", 16'({ram_addr, ram_data}), 16'({7'h10, 8'h80 + 8'(i)}));
      chk("ptr_step", 16'(data_ptr), 16'h0010 + 16'(steps[i]));
    end
    chk("we_cnt", 16'(we_cnt), 16'h0004);
    $display("test modes done");
    send(1'b1, 8'hC9);
    send(1'b1, 8'hFB);
    chk("banks_static", 16'({in_bank, out_bank}), 16'h0003);
    send(1'b0, 8'h3C);
    chk("row_bank", 16'(row_bank), 16'h0001);
    send(1'b1, 8'hCB);
    chk("banks_mux3", 16'({in_bank, out_bank}), 16'h0000);
    send(1'b1, 8'hF8);
    send(1'b1, 8'hC9);
    chk("banks_kept", 16'({in_bank, out_bank}), 16'h0003);
    $display("test banks done");
    sub_hi <= 1'b1;
    send(1'b1, 8'h4F);
    chk("ptr_last", 16'(data_ptr), 16'h004F);
    send(1'b1, 8'h4C);
    send(1'b1, 8'hE2);
    chk("subaddr", 16'(subaddr_cnt), 16'h0002);
    w0 = we_cnt;
    send(1'b0, 8'hA5);
    chk("wr_match", 16'(we_cnt - w0), 16'h0001);
    chk("ram_wr_wrap", 16'({ram_addr, ram_data}), 16'({7'h4C, 8'hA5}));
    chk("ptr_wrap", 16'({data_ptr, subaddr_cnt}), 16'({7'h04, 2'h3}));
    send(1'b0, 8'h5A);
    chk("wr_skip", 16'(we_cnt - w0), 16'h0001);
    chk("ptr_skip", 16'(data_ptr), 16'h000C);
    $display("test subaddress done");
    for (int i = 0; i < 4; i++) begin
      send(1'b1, {BLINK_SEL_PAT, i[0], 2'(i)});
      chk("blink", 16'({alt_blink, blink_rate}), 16'({i[0], 2'(i)}));
    end
    $display("test blink done");
    reg_wr(HOST_TX_ADDR, 16'h01D5);
    reg_wr(HOST_TX_ADDR, 16'h01C0);
    wait_idle();
    reg_rd(HOST_TX_ADDR, d);
    chk("tx_word", d, 16'h01D5);
    send(1'b1, 8'hE4);
    send(1'b1, 8'hFF);
    chk("unk_mode", 16'({display_on, bias_half, drive_mode}), 16'h0009);
    chk("unk_ptr", 16'({data_ptr, subaddr_cnt}), 16'({7'h0C, 2'h3}));
    chk("unk_blink", 16'({alt_blink, blink_rate}), 16'h0007);
    $display("test unknown done");
    summarize();
  end
endmodule : tb_top
